// ==== pkg/srvcr_pkg.sv ====
// package: register map, field layout and carrier types for the virtualisation capability registers
package srvcr_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [11:0] CAPS_OFFSET     = 12'h204;
	localparam logic [11:0] CTRL_OFFSET     = 12'h208;
	localparam logic [11:0] COUNTS_OFFSET   = 12'h20c;
	localparam logic [11:0] ENABLED_OFFSET  = 12'h210;
	localparam logic [11:0] ROUTING_OFFSET  = 12'h214;

	// ==========================================================
	// field positions
	localparam int CAPS_MIGRATION_BIT   = 0;
	localparam int CAPS_HIER_KEPT_BIT   = 1;
	localparam int CTRL_VF_ENABLE_BIT   = 0;
	localparam int CTRL_MIG_ENABLE_BIT  = 1;
	localparam int CTRL_MIG_IRQ_BIT     = 2;
	localparam int CTRL_MEM_ENABLE_BIT  = 3;
	localparam int CTRL_HIER_BIT        = 4;
	localparam int HALF_LSB             = 16;

	// ==========================================================
	// reset values and fixed values
	localparam logic        VF_ENABLE_RST    = 1'b0;
	localparam logic        MEM_ENABLE_RST   = 1'b0;
	localparam logic        HIER_RST         = 1'b0;
	localparam logic [15:0] ENABLED_RST      = 16'h0000;
	localparam logic [15:0] VF_STRIDE        = 16'h0001;

	// ==========================================================
	// axi4-lite response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// software-visible control state
	typedef struct packed {
		logic        vf_enable;
		logic        mem_enable;
		logic        hier;
		logic [15:0] enabled_count;
	} srvcr_ctrl_s;

	// whole slave state
	typedef struct packed {
		logic        aw_full;
		logic [11:0] aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		srvcr_ctrl_s ctrl;
	} srvcr_state_s;

	// status seen by the rest of the endpoint
	typedef struct packed {
		logic        vf_enable;
		logic        mem_enable;
		logic        hier;
		logic [15:0] enabled_count;
		logic [15:0] first_offset;
		logic [15:0] stride;
	} srvcr_status_s;

endpackage

// ==== hw/srvcr_regs.sv ====
// module: virtualisation capability and control registers behind an axi4-lite slave
`timescale 1ns/1ps

// Contract
// RL1: capabilities bit 0 reads 0, migration unsupported, read-only.
// RL2: capabilities bit 1 reads 1 only in lowest-numbered capable function.
// RL3: control bit 0 is virtual-function enable, read-write, resets 0.
// RL4: control bits 1 and 2 read-only zero.
// RL5: control bit 3 memory-space enable, read-write, resets 0.
// RL6: control bit 4 writable only in lowest capable function, resets 0.
// RL7: control bits 31:16 status, read-only zero.
// RL8: initial count bits 15:0 equal configured capacity.
// RL9: capacity in bits 31:16, read-only, set by parameter.
// RL10: enabled count bits 15:0 read-write, resets 0.
// RL11: enabled count writes accepted only while enable bit is 0.
// RL12: dependency link bits 31:16 read-only zero.
// RL13: physical function n uses routing id n.
// RL14: first offset is lower functions' counts plus function total minus index.
// RL15: stride in bits 31:16 reads fixed 1.
// RL16: virtual function m routing id is own id plus offset plus (m-1)*stride.
// RL17: reserved bits read 0, writes ignored.
module srvcr_regs #(
	parameter int unsigned  FUNC_INDEX                = 0,
	parameter int unsigned  PHYSICAL_FUNCTION_TOTAL   = 4,
	parameter bit           LOWEST_CAPABLE            = 1'b1,
	parameter logic [15:0]  VIRTUAL_FUNCTION_CAPACITY = 16'h0004,
	parameter logic [15:0]  FUNCTION0_VIRTUAL_COUNT   = 16'h0004,
	parameter logic [15:0]  FUNCTION1_VIRTUAL_COUNT   = 16'h0004,
	parameter logic [15:0]  FUNCTION2_VIRTUAL_COUNT   = 16'h0004
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [15:0]           vf_index,
	output logic [15:0]                pf_routing_id,
	output logic [15:0]                vf_routing_id,
	output srvcr_pkg::srvcr_status_s   status
);
	import srvcr_pkg::*;

	// ==========================================================
	// fixed values derived from parameters
	localparam logic [15:0] PF_ID = 16'(FUNC_INDEX);
	localparam logic [15:0] PF_TOTAL = 16'(PHYSICAL_FUNCTION_TOTAL);
	localparam logic [15:0] LOWER_SUM =
		((FUNC_INDEX > 0) ? FUNCTION0_VIRTUAL_COUNT : 16'h0000) +
		((FUNC_INDEX > 1) ? FUNCTION1_VIRTUAL_COUNT : 16'h0000) +
		((FUNC_INDEX > 2) ? FUNCTION2_VIRTUAL_COUNT : 16'h0000);
	localparam logic [15:0] FIRST_OFFSET = LOWER_SUM + PF_TOTAL - PF_ID; // [RL14]

	srvcr_state_s st_r;
	srvcr_state_s st_nxt;
	logic         wr_fire;
	logic         rd_fire;
	logic [31:0]  wmask;
	logic [31:0]  merged;
	logic [31:0]  rd_word;
	logic         rd_hit;
	logic         wr_hit;

	// ==========================================================
	// handshakes: one write and one read slot each
	assign s_axi_awready = !st_r.aw_full && !st_r.bvalid;
	assign s_axi_wready  = !st_r.w_full && !st_r.bvalid;
	assign s_axi_arready = !st_r.rvalid;
	assign wr_fire       = st_r.aw_full && st_r.w_full && !st_r.bvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	// byte strobes widened to a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{st_r.w_strb[i]}};
		end
	end

	// read decode on the address being offered
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr & 12'hffc)
			CAPS_OFFSET: begin
				rd_word[CAPS_MIGRATION_BIT] = 1'b0; // [RL1]
				rd_word[CAPS_HIER_KEPT_BIT] = LOWEST_CAPABLE; // [RL2] [RL17]
			end
			CTRL_OFFSET: begin
				rd_word[CTRL_VF_ENABLE_BIT]  = st_r.ctrl.vf_enable; // [RL3]
				rd_word[CTRL_MIG_ENABLE_BIT] = 1'b0; // [RL4]
				rd_word[CTRL_MIG_IRQ_BIT]    = 1'b0; // [RL4]
				rd_word[CTRL_MEM_ENABLE_BIT] = st_r.ctrl.mem_enable; // [RL5]
				rd_word[CTRL_HIER_BIT]       = st_r.ctrl.hier; // [RL6] [RL7] [RL17]
			end
			COUNTS_OFFSET: begin
				rd_word = {VIRTUAL_FUNCTION_CAPACITY, VIRTUAL_FUNCTION_CAPACITY}; // [RL8] [RL9]
			end
			ENABLED_OFFSET: begin
				rd_word = {16'h0000, st_r.ctrl.enabled_count}; // [RL10] [RL12]
			end
			ROUTING_OFFSET: begin
				rd_word = {VF_STRIDE, FIRST_OFFSET}; // [RL14] [RL15]
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// write decode: reserved and read-only bits never stored
	always_comb begin
		merged = st_r.w_data & wmask;
		wr_hit = 1'b1;
		unique case (st_r.aw_addr & 12'hffc)
			CAPS_OFFSET, CTRL_OFFSET, COUNTS_OFFSET, ENABLED_OFFSET, ROUTING_OFFSET: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_full = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_full = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if ((st_r.aw_addr & 12'hffc) == CTRL_OFFSET) begin
				if (wmask[CTRL_VF_ENABLE_BIT]) begin
					st_nxt.ctrl.vf_enable = merged[CTRL_VF_ENABLE_BIT]; // [RL3]
				end
				if (wmask[CTRL_MEM_ENABLE_BIT]) begin
					st_nxt.ctrl.mem_enable = merged[CTRL_MEM_ENABLE_BIT]; // [RL5]
				end
				if (LOWEST_CAPABLE && wmask[CTRL_HIER_BIT]) begin
					st_nxt.ctrl.hier = merged[CTRL_HIER_BIT]; // [RL6]
				end
			end
			// count locked while virtual functions are enabled
			if ((st_r.aw_addr & 12'hffc) == ENABLED_OFFSET && !st_r.ctrl.vf_enable) begin // [RL11]
				st_nxt.ctrl.enabled_count = (merged[15:0]) |
					(st_r.ctrl.enabled_count & ~wmask[15:0]); // [RL10]
			end
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = rd_word;
			st_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r                    <= '0;
			st_r.ctrl.vf_enable     <= VF_ENABLE_RST;
			st_r.ctrl.mem_enable    <= MEM_ENABLE_RST;
			st_r.ctrl.hier          <= HIER_RST;
			st_r.ctrl.enabled_count <= ENABLED_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// bus outputs
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp  = st_r.bresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata  = st_r.rdata;
	assign s_axi_rresp  = st_r.rresp;

	// routing ids for this function and a chosen virtual function
	assign pf_routing_id = PF_ID; // [RL13]
	assign vf_routing_id = (vf_index == 16'h0000) ? 16'h0000 :
		16'(PF_ID + FIRST_OFFSET + 16'(32'(vf_index - 16'h0001) * 32'(VF_STRIDE))); // [RL16]

	// status to the endpoint
	assign status.vf_enable     = st_r.ctrl.vf_enable;
	assign status.mem_enable    = st_r.ctrl.mem_enable;
	assign status.hier          = st_r.ctrl.hier;
	assign status.enabled_count = st_r.ctrl.enabled_count;
	assign status.first_offset  = FIRST_OFFSET;
	assign status.stride        = VF_STRIDE;

endmodule

// ==== verification/srvcr_chk.sv ====
// checker: port properties of the capability register slave
`timescale 1ns/1ps
module srvcr_chk #(
	parameter int unsigned FUNC_INDEX = 0,
	parameter int unsigned PHYSICAL_FUNCTION_TOTAL = 4
) (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic [11:0]             s_axi_araddr,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [1:0]              s_axi_rresp,
	input wire logic                    s_axi_rvalid,
	input wire logic [15:0]             vf_index,
	input wire logic [15:0]             pf_routing_id,
	input wire logic [15:0]             vf_routing_id,
	input wire srvcr_pkg::srvcr_status_s status
);
	import srvcr_pkg::*;
	logic [11:0] ra_r;
	logic        rv;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// address of the read under way
	always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
	assign rv = s_axi_rvalid && s_axi_rresp == RESP_OKAY;
	// ==========================================================
	// routing and fixed fields
	a_pf_route: assert property (pf_routing_id == 16'(FUNC_INDEX)) else $error("pf id");
	a_first_offset: assert property (status.first_offset == 16'(PHYSICAL_FUNCTION_TOTAL)) else $error("offset");
	a_stride_fixed: assert property (status.stride == VF_STRIDE) else $error("stride");
	a_vf_route: assert property (vf_index != 16'h0 |->
		vf_routing_id == pf_routing_id + status.first_offset + (vf_index - 16'h1) * status.stride) else $error("vf id");
	// ==========================================================
	// control state
	a_count_lock: assert property (status.vf_enable |=> $stable(status.enabled_count)) else $error("lock");
	a_reset_clear: assert property ($rose(aresetn) |-> status.vf_enable == 1'b0 &&
		status.mem_enable == 1'b0 && status.hier == 1'b0 && status.enabled_count == 16'h0) else $error("reset");
	// ==========================================================
	// read data against state
	a_caps_read: assert property (rv && ra_r == CAPS_OFFSET |-> s_axi_rdata == 32'h2) else $error("caps");
	a_ctrl_read: assert property (rv && ra_r == CTRL_OFFSET |-> s_axi_rdata ==
		{27'h0, status.hier, status.mem_enable, 2'h0, status.vf_enable}) else $error("ctrl");
	a_counts_read: assert property (rv && ra_r == COUNTS_OFFSET |-> s_axi_rdata[15:0] == s_axi_rdata[31:16]) else $error("init");
	a_enab_read: assert property (rv && ra_r == ENABLED_OFFSET |-> s_axi_rdata == {16'h0, status.enabled_count}) else $error("count");
	c_locked: cover property (status.vf_enable && status.enabled_count != 16'h0);
	c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_vf: cover property (vf_index == 16'h3);
endmodule
bind srvcr_regs srvcr_chk #(.FUNC_INDEX(FUNC_INDEX), .PHYSICAL_FUNCTION_TOTAL(PHYSICAL_FUNCTION_TOTAL)) u_chk (.aclk, .aresetn,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .vf_index, .pf_routing_id,
	.vf_routing_id, .status);

// ==== verification/srvcr_host.sv ====
// host model: axi4-lite master issuing configuration reads and writes
`timescale 1ns/1ps
module srvcr_host (
	input wire logic         aclk,
	output logic [11:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input wire logic         s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input wire logic         s_axi_wready,
	input wire logic [1:0]   s_axi_bresp,
	input wire logic         s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [11:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic [1:0]   s_axi_rresp,
	input wire logic         s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// write: hold each channel until taken, payload inverted once released
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// read: hold address until taken, data taken at the rvalid edge
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ==== verification/testbench.sv ====
// testbench: register map, count lock and routing ids through the host model
`timescale 1ns/1ps
module testbench;
	import srvcr_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] vf_index = 16'h0, pf_routing_id, vf_routing_id;
	srvcr_status_s status;
	int fails = 0, checks = 0, cyc = 0;
	srvcr_regs u_dut (.*);
	srvcr_host u_host (.*);
	always #2.5 aclk = ~aclk;
	// ==========================================================
	// compare, verdict and hang guard
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	task wrap_up;
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			wrap_up;
		end
	end
	// ==========================================================
	// bus wrappers with response checks
	task wc(input logic [11:0] a, input logic [31:0] d);
		u_host.wr(a, d, rsp);
		chk(32'(rsp), 32'(RESP_OKAY));
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		u_host.rd(a, rd_d, rsp);
		chk(32'(rsp), 32'(RESP_OKAY));
		chk(rd_d, e);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rc(CAPS_OFFSET, 32'h2);
		rc(CTRL_OFFSET, 32'h0);
		rc(COUNTS_OFFSET, 32'h00040004);
		rc(ENABLED_OFFSET, 32'h0);
		rc(ROUTING_OFFSET, 32'h00010004);
		wc(ENABLED_OFFSET, 32'hffff0003); // count set before enable
		rc(ENABLED_OFFSET, 32'h3);
		wc(CTRL_OFFSET, 32'hffffffff);
		rc(CTRL_OFFSET, 32'h19);
		wc(ENABLED_OFFSET, 32'h7);
		rc(ENABLED_OFFSET, 32'h3);
		wc(CTRL_OFFSET, 32'h0);
		wc(ENABLED_OFFSET, 32'h2);
		rc(ENABLED_OFFSET, 32'h2);
		wc(CAPS_OFFSET, 32'hffffffff);
		wc(COUNTS_OFFSET, 32'h0);
		rc(CAPS_OFFSET, 32'h2);
		rc(COUNTS_OFFSET, 32'h00040004);
		u_host.rd(12'h300, rd_d, rsp);
		chk(32'(rsp), 32'(RESP_SLVERR));
		chk(rd_d, 32'h0);
		u_host.wr(12'h300, 32'h1, rsp);
		chk(32'(rsp), 32'(RESP_SLVERR));
		for (int m = 1; m < 4; m++) begin
			@(posedge aclk) vf_index <= 16'(m);
			@(posedge aclk) #1;
			chk(32'(vf_routing_id), 32'(m + 3));
			chk(32'(pf_routing_id), 32'h0);
		end
		wc(CTRL_OFFSET, 32'h9);
		@(posedge aclk) aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(CTRL_OFFSET, 32'h0);
		rc(ENABLED_OFFSET, 32'h0);
		wrap_up;
	end
endmodule
